// ==== rtl/bfp_pkg.sv ====
// bfp_pkg: constants and carriers for the burst flash pin interface
// assumes one 100 MHz core clock; host pins sampled synchronously
// Function
// - the first rising clock edge with the address strobe low latches the address and starts a burst.
// - after the first burst word is out, each further rising clock edge advances the address by one.
// - in asynchronous mode a low address strobe means the address inputs carry a valid address.
// - while the address strobe is high the address inputs are ignored.
// - upper address bits are address only; lower ones share pins with data.
// - a low hardware reset resets the device and returns it to array read.
// - a low write-protect blocks program and erase of the two protected sectors.
// - a high-voltage accelerate input speeds programming and enters unlock bypass; low disables programming.
// - the ready output is high when the bus word is valid, low when not; here it is high throughout the burst and asynchronous read states.
package bfp_pkg;
   localparam int ADQ_W = 16;
   localparam int UPA_W = 7;
   localparam int ADDR_W = ADQ_W + UPA_W;
   localparam int SECT_W = 8;
   // sector index is the upper address bits above a 32K-word sector
   localparam int SECT_LSB = ADDR_W - SECT_W;
   localparam logic [SECT_W-1:0] PROT_SECT_A = 8'h00;
   localparam logic [SECT_W-1:0] PROT_SECT_B = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
   localparam logic [ADQ_W-1:0] DATA_RST = 16'h0000;
   // initial access latency in clocks before the first burst word
   localparam int LAT_NS = 30;
   localparam int CLK_NS = 10;
   localparam int LAT_CYC = (LAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int LAT_W = 4;

   typedef enum logic [1:0] {
      BFP_IDLE  = 2'b00,
      BFP_ASYNC = 2'b01,
      BFP_WAIT  = 2'b10,
      BFP_BURST = 2'b11
   } bfp_state_e;

   typedef struct packed {
      logic prog_ok;
      logic accel;
      logic bypass;
   } bfp_prog_s;
endpackage : bfp_pkg

// ==== rtl/bfp_sync_edge.sv ====
// bfp_sync_edge: two-flop stage plus rising edge detect on a host pin
// assumes the pin may be asynchronous to core_clk_in
`timescale 1ns/1ps
module bfp_sync_edge (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign level_out = s2_r;
   assign rise_out = s2_r & ~s3_r;
endmodule : bfp_sync_edge

// ==== rtl/bfp_pin_if.sv ====
// bfp_pin_if: host pin behaviour of a burst flash, device side
// assumes array data arrives one core clock after arr_addr_out changes
`timescale 1ns/1ps
module bfp_pin_if
   import bfp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic burst_clk_in,
   input wire logic addr_valid_strobe_n,
   input wire logic [UPA_W-1:0] addr_hi_in,
   input wire logic [ADQ_W-1:0] adq_in,
   output logic [ADQ_W-1:0] adq_out,
   output logic adq_oe_out,
   input wire logic oe_n_in,
   input wire logic hw_reset_n_in,
   input wire logic wp_n_in,
   input wire logic program_accel_input,
   input wire logic accel_hv_in,
   input wire logic burst_mode_in,
   input wire logic [ADQ_W-1:0] arr_data_in,
   output logic [ADDR_W-1:0] arr_addr_out,
   input wire logic erase_prog_req_in,
   output logic erase_prog_ok_out,
   output bfp_prog_s prog_out,
   output logic ready_out
);
   // ------------------------------------------------------------
   // burst clock pin synchroniser
   // ------------------------------------------------------------
   logic clk_lvl;
   logic clk_rise;

   bfp_sync_edge u_clk_sync (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .pin_in(burst_clk_in),
      .level_out(clk_lvl),
      .rise_out(clk_rise)
   );

   // ------------------------------------------------------------
   // read state machine
   // ------------------------------------------------------------
   bfp_state_e state_r;
   bfp_state_e state_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [LAT_W-1:0] lat_r;
   logic [ADQ_W-1:0] dout_r;
   logic rdy_r;
   logic avd_low;
   logic [ADDR_W-1:0] pin_addr;

   assign avd_low = ~addr_valid_strobe_n;
   assign pin_addr = {addr_hi_in, adq_in};

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BFP_IDLE: begin
            if (burst_mode_in && avd_low && clk_rise) begin
               state_nxt = BFP_WAIT;
            end else if (!burst_mode_in && avd_low) begin
               state_nxt = BFP_ASYNC;
            end
         end
         BFP_ASYNC: begin
            if (burst_mode_in) begin
               state_nxt = BFP_IDLE;
            end
         end
         BFP_WAIT: begin
            if (avd_low && clk_rise) begin
               state_nxt = BFP_WAIT;
            end else if (clk_rise && lat_r == LAT_W'(1)) begin
               state_nxt = BFP_BURST;
            end
         end
         BFP_BURST: begin
            if (avd_low && clk_rise) begin
               state_nxt = BFP_WAIT;
            end
         end
         default: state_nxt = BFP_IDLE;
      endcase
   end

   // reset pin returns the device to array read
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= BFP_IDLE;
      end else if (!hw_reset_n_in) begin
         state_r <= BFP_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // address capture and burst advance
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         addr_r <= ADDR_RST;
      end else if (!hw_reset_n_in) begin
         addr_r <= ADDR_RST;
      end else if (avd_low && (state_nxt == BFP_WAIT) && clk_rise) begin
         addr_r <= pin_addr;
      end else if (state_r == BFP_BURST && clk_rise) begin
         addr_r <= addr_r + ADDR_W'(1);
      end else if (avd_low && !burst_mode_in && !clk_lvl) begin
         addr_r <= pin_addr;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lat_r <= '0;
      end else if (avd_low && clk_rise) begin
         lat_r <= LAT_W'(LAT_CYC);
      end else if (clk_rise && lat_r != '0) begin
         lat_r <= lat_r - LAT_W'(1);
      end
   end

   assign arr_addr_out = addr_r;

   // data and ready
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dout_r <= DATA_RST;
      end else begin
         dout_r <= arr_data_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdy_r <= 1'b0;
      end else if (!hw_reset_n_in) begin
         rdy_r <= 1'b0;
      end else begin
         rdy_r <= (state_nxt == BFP_BURST)
                  || (state_nxt == BFP_ASYNC);
      end
   end

   assign adq_out = dout_r;
   assign adq_oe_out = ~oe_n_in & addr_valid_strobe_n & hw_reset_n_in
                       & (state_r != BFP_IDLE);
   assign ready_out = rdy_r;

   // ------------------------------------------------------------
   // protection and acceleration
   // ------------------------------------------------------------
   logic prot_hit;
   assign prot_hit = (addr_r[ADDR_W-1:SECT_LSB] == PROT_SECT_A)
                  || (addr_r[ADDR_W-1:SECT_LSB] == PROT_SECT_B);

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         erase_prog_ok_out <= 1'b0;
         prog_out <= '0;
      end else begin
         erase_prog_ok_out <= erase_prog_req_in & hw_reset_n_in
                              & program_accel_input
                              & ~(~wp_n_in & prot_hit);
         prog_out.prog_ok <= program_accel_input;
         prog_out.accel <= program_accel_input & accel_hv_in;
         prog_out.bypass <= program_accel_input & accel_hv_in;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_burst_start: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (state_r == BFP_IDLE && burst_mode_in && avd_low
      && clk_rise && hw_reset_n_in) |=> (state_r == BFP_WAIT
      && addr_r == $past(pin_addr)))
      else $error("burst start not taken");
   a_burst_step: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (state_r == BFP_BURST && clk_rise && !avd_low
      && hw_reset_n_in) |=> addr_r == $past(addr_r) + ADDR_W'(1))
      else $error("burst address not advanced");
   a_hold_idle: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (addr_valid_strobe_n && !clk_rise && state_r != BFP_BURST
      && hw_reset_n_in) |=> $stable(addr_r))
      else $error("address moved with strobe high");
   a_async_take: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (avd_low && !burst_mode_in && !clk_lvl && !clk_rise
      && hw_reset_n_in) |=> addr_r == $past(pin_addr))
      else $error("async address not taken");
   a_reset_pin: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) !hw_reset_n_in |=> (state_r == BFP_IDLE
      && addr_r == ADDR_RST) ##1 !ready_out)
      else $error("reset pin did not idle device");
   a_wp_block: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (!wp_n_in && prot_hit) |=> !erase_prog_ok_out)
      else $error("protected sector not blocked");
   a_accel_mode: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (program_accel_input && accel_hv_in) |=>
      (prog_out.accel && prog_out.bypass))
      else $error("accelerate mode not entered");
   a_prog_off: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) !program_accel_input |=> (!prog_out.prog_ok
      && !erase_prog_ok_out))
      else $error("programming not disabled");
   a_ready_burst: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) ready_out == (state_r == BFP_BURST
      || state_r == BFP_ASYNC))
      else $error("ready out of step with read state");
   a_lat_done: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (state_r == BFP_WAIT && clk_rise && !avd_low
      && lat_r == LAT_W'(1) && hw_reset_n_in) |=>
      (state_r == BFP_BURST && ready_out))
      else $error("burst not ready after latency");
   a_async_ready: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) (state_r == BFP_IDLE && avd_low && !burst_mode_in
      && hw_reset_n_in) |=> (state_r == BFP_ASYNC && ready_out))
      else $error("async read not ready");
   a_adq_turn: assert property (@(posedge core_clk_in) disable iff
      (!arst_n_in) !addr_valid_strobe_n |-> !adq_oe_out)
      else $error("data driven while address phase");
endmodule : bfp_pin_if

// ==== test/bfp_host_model.sv ====
// bfp_host_model: host controller driving strobe, burst clock and address
// assumes its tasks are called from the bench at a falling core edge
`timescale 1ns/1ps
module bfp_host_model
   import bfp_pkg::*;
(
   input wire logic core_clk_in,
   output logic burst_clk_out,
   output logic strobe_n_out,
   output logic [UPA_W-1:0] addr_hi_out,
   output logic [ADQ_W-1:0] adq_out
);
   // clock stands low outside bursts
   initial begin
      burst_clk_out = 1'b0;
      strobe_n_out = 1'b1;
      addr_hi_out = '0;
      adq_out = '0;
   end
   // -------------------------------------------------------------
   // pin tasks
   // -------------------------------------------------------------
   // one burst clock period of nine core cycles
   task automatic rise();
      @(negedge core_clk_in) burst_clk_out = 1'b1;
      repeat (4) @(negedge core_clk_in);
      burst_clk_out = 1'b0;
      repeat (4) @(negedge core_clk_in);
   endtask : rise
   // a released bus shows the inverse of the address
   task automatic put(input logic s, input logic [ADDR_W-1:0] a);
      @(negedge core_clk_in);
      strobe_n_out = s;
      {addr_hi_out, adq_out} = s ? ~a : a;
   endtask : put
   task automatic burst(input logic [ADDR_W-1:0] a);
      put(1'b0, a);
      rise();
      put(1'b1, a);
   endtask : burst
   // burst clock is left low throughout
   task automatic async(input logic [ADDR_W-1:0] a);
      put(1'b0, a);
      repeat (2) @(negedge core_clk_in);
      put(1'b1, a);
   endtask : async
endmodule : bfp_host_model

// ==== test/tb_burst_flash_pin_interface.sv ====
// tb_burst_flash_pin_interface: directed checks of the pin interface
// assumes bfp_pin_if and bfp_host_model; 100 MHz core clock
`timescale 1ns/1ps
module tb_burst_flash_pin_interface
   import bfp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic oe_n = 1'b0, hw_n = 1'b1, wp_n = 1'b1, acc = 1'b1, hv = 1'b0;
   logic bmode = 1'b1, req = 1'b0, bclk, stb_n, oe, ok, rdy;
   logic [UPA_W-1:0] ahi;
   logic [ADQ_W-1:0] adq, dq, arr_d = '0;
   logic [ADDR_W-1:0] aa;
   bfp_prog_s prog;
   int mismatches = 0;
   int check_count = 0;
   always #5 clk = ~clk;
   // array word is the inverse of the low address bits
   always @(negedge clk) arr_d <= ~aa[ADQ_W-1:0];
   bfp_host_model host (.core_clk_in(clk), .burst_clk_out(bclk),
      .strobe_n_out(stb_n), .addr_hi_out(ahi), .adq_out(adq));
   bfp_pin_if dut (.core_clk_in(clk), .arst_n_in(rst_n), .burst_clk_in(bclk),
      .addr_valid_strobe_n(stb_n), .addr_hi_in(ahi), .adq_in(adq),
      .adq_out(dq), .adq_oe_out(oe), .oe_n_in(oe_n), .hw_reset_n_in(hw_n),
      .wp_n_in(wp_n), .program_accel_input(acc), .accel_hv_in(hv),
      .burst_mode_in(bmode), .arr_data_in(arr_d), .arr_addr_out(aa),
      .erase_prog_req_in(req), .erase_prog_ok_out(ok), .prog_out(prog),
      .ready_out(rdy));
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   task automatic chk(input logic [ADDR_W-1:0] got, exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // start near a carry into the upper address bits
   task automatic t_burst();
      logic [ADDR_W-1:0] e;
      logic [ADQ_W-1:0] d;
      e = {7'h05, 16'hFFFE};
      host.burst(e);
      host.rise();
      host.rise();
      chk(rdy, 1'b0);
      host.rise();
      chk(rdy, 1'b1);
      for (int k = 0; k < 4; k++) begin
         if (k > 0) begin
            host.rise();
            e = e + 23'h000001;
         end
         d = ~e[ADQ_W-1:0];
         chk(aa, e);
         chk(dq, d);
         chk(oe, 1'b1);
      end
      // output enable high must release the shared bus
      oe_n = 1'b1;
      @(negedge clk);
      chk(oe, 1'b0);
      oe_n = 1'b0;
   endtask : t_burst
   task automatic t_hwrst();
      @(negedge clk) hw_n = 1'b0;
      repeat (3) @(negedge clk);
      chk(aa, 23'h000000);
      chk(rdy, 1'b0);
      hw_n = 1'b1;
   endtask : t_hwrst
   task automatic t_ignore();
      host.put(1'b1, 23'h2AAAAA);
      host.rise();
      host.rise();
      chk(aa, 23'h000000);
      chk(rdy, 1'b0);
      chk(oe, 1'b0);
   endtask : t_ignore
   // both protected sectors, then an open one
   task automatic t_prot();
      logic [ADDR_W-1:0] sa [3] = '{23'h000010, 23'h008000, 23'h010000};
      @(negedge clk) bmode = 1'b0;
      for (int i = 0; i < 3; i++) begin
         host.async(sa[i]);
         repeat (2) @(negedge clk);
         chk(rdy, 1'b1);
         chk(aa, sa[i]);
         wp_n = 1'b0;
         req = 1'b1;
         repeat (2) @(negedge clk);
         chk(ok, (i == 2));
         wp_n = 1'b1;
         repeat (2) @(negedge clk);
         chk(ok, 1'b1);
         req = 1'b0;
      end
      chk(prog, 3'b100);
      hv = 1'b1;
      repeat (2) @(negedge clk);
      chk(prog, 3'b111);
      hv = 1'b0;
      acc = 1'b0;
      req = 1'b1;
      repeat (2) @(negedge clk);
      chk(ok, 1'b0);
      chk(prog.prog_ok, 1'b0);
   endtask : t_prot
   // -------------------------------------------------------------
   // sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_burst();
      t_hwrst();
      t_ignore();
      t_prot();
      report_and_stop();
   end
   initial begin
      #50000;
      mismatches++;
      report_and_stop();
   end
endmodule : tb_burst_flash_pin_interface
